// *** adcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Converter core
    input wire logic conv_done_in,
    input wire logic [11:0] conv_data_in,
    output logic conv_start_out,
    output logic conv_power_out,
    output logic [1:0] mux_source_out,
    output logic [7:0] mux_pin_sel_out,
    output logic [1:0] vref_sel_out,
    output logic [2:0] conv_clk_div_out,
    // Pin function control
    output logic [7:0] analog_pin_enable_bits_out,
    output logic [7:0] io_function_disable_out,
    output logic [7:0] pull_high_disable_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] adcc_source_decode(input logic [2:0] code);
        case (code)
            3'h1: adcc_source_decode = ADCC_MUX_BANDGAP;
            3'h3: adcc_source_decode = ADCC_MUX_PROT_AMP;
            3'h2, 3'h4: adcc_source_decode = ADCC_MUX_GROUND;
            default: adcc_source_decode = ADCC_MUX_EXTERNAL;
        endcase
    endfunction : adcc_source_decode

    function automatic logic [7:0] adcc_pin_decode(input logic [3:0] chan);
        logic [7:0] onehot;
        onehot = 8'h00;
        if (!chan[3]) begin
            onehot[chan[2:0]] = 1'b1;
        end
        adcc_pin_decode = onehot;
    endfunction : adcc_pin_decode

    // Every register fits in one byte; the upper bus bits always read zero
    function automatic logic [31:0] adcc_byte_word(input logic [7:0] value);
        adcc_byte_word = {24'h0, value};
    endfunction : adcc_byte_word

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic start_q, start_d;
    logic busy_q, busy_d;
    logic enable_q, enable_d;
    logic format_q, format_d;
    logic [3:0] chan_q, chan_d;
    logic [7:0] src_cfg_q, src_cfg_d;
    logic [7:0] pin_en_q, pin_en_d;
    logic [11:0] result_q, result_d;
    logic irq_status_q, irq_status_d;
    logic irq_mask_q, irq_mask_d;
    adcc_state_type state_q, state_d;
    logic conv_start_q, conv_start_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [1:0] mux_source_q, mux_source_d;
    logic [7:0] mux_pin_q, mux_pin_d;
    logic irq_q, irq_d;

    logic bus_access;
    logic wr_access;
    logic rd_access;
    logic [7:0] wbyte;
    logic [7:0] result_low;
    logic [7:0] result_high;
    logic addr_ok;
    logic done_event;

    assign bus_access = psel_in && penable_in && !pready_q;
    assign wr_access = bus_access && pwrite_in;
    assign rd_access = bus_access && !pwrite_in;
    assign wbyte = pwdata_in[7:0];
    assign done_event = (state_q == ADCC_CONVERT) && conv_done_in;

    // ------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------
    always_comb begin
        if (format_q) begin
            result_high = {4'h0, result_q[11:8]};
            result_low = result_q[7:0];
        end else begin
            result_high = result_q[11:4];
            result_low = {result_q[3:0], 4'h0};
        end
    end

    always_comb begin
        case (paddr_in)
            ADCC_ADDR_RESULT_LOW, ADCC_ADDR_RESULT_HIGH, ADCC_ADDR_CONV_CTRL, ADCC_ADDR_SRC_CFG,
            ADCC_ADDR_PIN_EN, ADCC_ADDR_IRQ_STATUS, ADCC_ADDR_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_comb begin
        start_d = start_q;
        enable_d = enable_q;
        format_d = format_q;
        chan_d = chan_q;
        src_cfg_d = src_cfg_q;
        pin_en_d = pin_en_q;
        irq_mask_d = irq_mask_q;
        // Unmapped and read-only offsets fall to default, so the write is dropped
        if (wr_access) begin
            case (paddr_in)
                ADCC_ADDR_CONV_CTRL: begin
                    // Busy is owned by the sequencer; its written bit is ignored
                    start_d = wbyte[ADCC_CTRL_START_BIT];
                    enable_d = wbyte[ADCC_CTRL_ENABLE_BIT];
                    format_d = wbyte[ADCC_CTRL_FORMAT_BIT];
                    chan_d = wbyte[ADCC_CTRL_CHAN_LSB +: 4];
                end
                ADCC_ADDR_SRC_CFG: src_cfg_d = wbyte;
                ADCC_ADDR_PIN_EN: pin_en_d = wbyte;
                ADCC_ADDR_IRQ_MASK: irq_mask_d = wbyte[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            start_q <= ADCC_CONV_CTRL_RST[ADCC_CTRL_START_BIT];
            enable_q <= ADCC_CONV_CTRL_RST[ADCC_CTRL_ENABLE_BIT];
            format_q <= ADCC_CONV_CTRL_RST[ADCC_CTRL_FORMAT_BIT];
            chan_q <= ADCC_CONV_CTRL_RST[3:0];
            src_cfg_q <= ADCC_SRC_CFG_RST;
            pin_en_q <= ADCC_PIN_EN_RST;
            irq_mask_q <= ADCC_IRQ_RST[0];
        end else begin
            start_q <= start_d;
            enable_q <= enable_d;
            format_q <= format_d;
            chan_q <= chan_d;
            src_cfg_q <= src_cfg_d;
            pin_en_q <= pin_en_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always_comb begin
        irq_status_d = irq_status_q;
        if (wr_access && (paddr_in == ADCC_ADDR_IRQ_STATUS) && wbyte[0]) begin
            irq_status_d = 1'b0;
        end
        // Set wins over a same-cycle clear, so no completion is lost
        if (done_event) begin
            irq_status_d = 1'b1;
        end
        irq_d = irq_status_d && irq_mask_d;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            irq_status_q <= ADCC_IRQ_RST[0];
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Bus reply
    // ------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        pready_d = bus_access;
        pslverr_d = bus_access && !addr_ok;
        if (rd_access) begin
            case (paddr_in)
                ADCC_ADDR_RESULT_LOW: prdata_d = adcc_byte_word(result_low);
                ADCC_ADDR_RESULT_HIGH: prdata_d = adcc_byte_word(result_high);
                ADCC_ADDR_CONV_CTRL: prdata_d = adcc_byte_word({start_q, busy_q, enable_q, format_q, chan_q});
                ADCC_ADDR_SRC_CFG: prdata_d = adcc_byte_word(src_cfg_q);
                ADCC_ADDR_PIN_EN: prdata_d = adcc_byte_word(pin_en_q);
                ADCC_ADDR_IRQ_STATUS: prdata_d = {31'h0, irq_status_q};
                ADCC_ADDR_IRQ_MASK: prdata_d = {31'h0, irq_mask_q};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        result_d = result_q;
        conv_start_d = 1'b0;
        case (state_q)
            ADCC_IDLE: begin
                if (enable_q && start_q) begin
                    state_d = ADCC_ARMED;
                end
            end
            ADCC_ARMED: begin
                // Falling edge of start completes the 0-1-0 sequence
                if (!enable_q) begin
                    state_d = ADCC_IDLE;
                end else if (!start_q) begin
                    state_d = ADCC_CONVERT;
                    busy_d = 1'b1;
                    conv_start_d = 1'b1;
                end
            end
            ADCC_CONVERT: begin
                if (!enable_q) begin
                    state_d = ADCC_IDLE;
                    busy_d = 1'b0;
                end else if (conv_done_in) begin
                    state_d = ADCC_IDLE;
                    busy_d = 1'b0;
                    result_d = conv_data_in;
                end
            end
            default: begin
                state_d = ADCC_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // Result only moves on a completed conversion, so a disabled converter keeps it
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            busy_q <= ADCC_CONV_CTRL_RST[ADCC_CTRL_BUSY_BIT];
            result_q <= ADCC_RESULT_RST;
            state_q <= ADCC_IDLE;
            conv_start_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            result_q <= result_d;
            state_q <= state_d;
            conv_start_q <= conv_start_d;
        end
    end

    // ------------------------------------------------------------
    // Source routing
    // ------------------------------------------------------------
    always_comb begin
        mux_source_d = adcc_source_decode(src_cfg_q[ADCC_CFG_SRC_LSB +: 3]);
        // Internal source forces external pins off so sources never short
        mux_pin_d = (mux_source_d == ADCC_MUX_EXTERNAL) ? adcc_pin_decode(chan_q) : 8'h00;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            mux_source_q <= ADCC_MUX_EXTERNAL;
            mux_pin_q <= 8'h00;
        end else begin
            mux_source_q <= mux_source_d;
            mux_pin_q <= mux_pin_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign conv_start_out = conv_start_q;
    assign conv_power_out = enable_q;
    assign mux_source_out = mux_source_q;
    assign mux_pin_sel_out = mux_pin_q;
    assign vref_sel_out = src_cfg_q[ADCC_CFG_VREF_LSB +: 2];
    assign conv_clk_div_out = src_cfg_q[ADCC_CFG_CLKDIV_LSB +: 3];
    assign analog_pin_enable_bits_out = pin_en_q;
    assign io_function_disable_out = pin_en_q;
    assign pull_high_disable_out = pin_en_q;
    assign irq_out = irq_q;
endmodule : adcc_top
`default_nettype wire

// *** adcc_pkg.sv ***
package adcc_pkg;
    // Register byte addresses on the APB bus
    localparam logic [7:0] ADCC_ADDR_RESULT_LOW = 8'h00;
    localparam logic [7:0] ADCC_ADDR_RESULT_HIGH = 8'h04;
    localparam logic [7:0] ADCC_ADDR_CONV_CTRL = 8'h08;
    localparam logic [7:0] ADCC_ADDR_SRC_CFG = 8'h0C;
    localparam logic [7:0] ADCC_ADDR_PIN_EN = 8'h10;
    localparam logic [7:0] ADCC_ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADCC_ADDR_IRQ_MASK = 8'h18;

    // Conversion control field positions
    localparam int ADCC_CTRL_START_BIT = 7;
    localparam int ADCC_CTRL_BUSY_BIT = 6;
    localparam int ADCC_CTRL_ENABLE_BIT = 5;
    localparam int ADCC_CTRL_FORMAT_BIT = 4;
    localparam int ADCC_CTRL_CHAN_LSB = 0;
    // Source configuration field positions
    localparam int ADCC_CFG_SRC_LSB = 5;
    localparam int ADCC_CFG_VREF_LSB = 3;
    localparam int ADCC_CFG_CLKDIV_LSB = 0;

    // Reset values
    localparam logic [7:0] ADCC_CONV_CTRL_RST = 8'h00;
    localparam logic [7:0] ADCC_SRC_CFG_RST = 8'h00;
    localparam logic [7:0] ADCC_PIN_EN_RST = 8'h00;
    localparam logic [11:0] ADCC_RESULT_RST = 12'h000;
    localparam logic [7:0] ADCC_IRQ_RST = 8'h00;

    // Analog mux selection toward the converter core
    localparam logic [1:0] ADCC_MUX_EXTERNAL = 2'h0;
    localparam logic [1:0] ADCC_MUX_BANDGAP = 2'h1;
    localparam logic [1:0] ADCC_MUX_PROT_AMP = 2'h2;
    localparam logic [1:0] ADCC_MUX_GROUND = 2'h3;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_ARMED,
        ADCC_CONVERT
    } adcc_state_type;
endpackage : adcc_pkg

// *** adcc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_chk
    import adcc_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic conv_start_out,
    input wire logic conv_power_out,
    input wire logic [1:0] mux_source_out,
    input wire logic [7:0] mux_pin_sel_out,
    input wire logic [7:0] analog_pin_enable_bits_out,
    input wire logic [7:0] io_function_disable_out,
    input wire logic [7:0] pull_high_disable_out
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    ready_after_access_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("no ready one cycle into access");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held beyond one cycle");
    error_reply_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error reply without ready or with data");
    byte_regs_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse wider than one cycle");
    start_powered_a: assert property (conv_start_out |-> conv_power_out)
        else $error("start issued while converter off");
    pin_function_a: assert property (io_function_disable_out == analog_pin_enable_bits_out &&
        pull_high_disable_out == analog_pin_enable_bits_out) else $error("pin function not following enables");
    one_source_a: assert property ($onehot0(mux_pin_sel_out) &&
        (mux_source_out == ADCC_MUX_EXTERNAL || mux_pin_sel_out == 8'h00)) else $error("source routing clash");
endmodule : adcc_chk

bind adcc_top adcc_chk i_chk (.clock_in, .sys_rst_in, .psel_in, .penable_in, .prdata_out, .pready_out,
    .pslverr_out, .conv_start_out, .conv_power_out, .mux_source_out, .mux_pin_sel_out,
    .analog_pin_enable_bits_out, .io_function_disable_out, .pull_high_disable_out);
`default_nettype wire

// *** adcc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic power_in,
    input wire logic [3:0] delay_in,
    input wire logic [11:0] value_in,
    output logic done_out,
    output logic [11:0] data_out
);
    // ----------------------------------------
    // Converter core
    // ----------------------------------------
    logic run;
    logic [3:0] cnt;
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !power_in) begin
            run <= 1'b0;
            cnt <= 4'h0;
        end else if (start_in) begin
            run <= 1'b1;
            cnt <= delay_in;
        end else if (run && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else begin
            run <= 1'b0;
        end
    end
    assign done_out = run && cnt == 4'h0;
    // Data only valid with done; scrambled otherwise so stale capture shows
    assign data_out = done_out ? value_in : ~value_in;
endmodule : adcc_core_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
    import adcc_pkg::*;
;
    logic clock_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rdat;
    logic pready_out, pslverr_out, conv_done_in, conv_start_out, conv_power_out, irq_out, rerr;
    logic [11:0] conv_data_in, value = 12'h000;
    logic [3:0] delay = 4'h0;
    logic [1:0] mux_source_out, vref_sel_out;
    logic [2:0] conv_clk_div_out;
    logic [7:0] mux_pin_sel_out, analog_pin_enable_bits_out, io_function_disable_out, pull_high_disable_out;
    int miscompares = 0, n_compared = 0;

    adcc_top i_dut (.clock_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .conv_done_in, .conv_data_in, .conv_start_out, .conv_power_out,
        .mux_source_out, .mux_pin_sel_out, .vref_sel_out, .conv_clk_div_out, .analog_pin_enable_bits_out,
        .io_function_disable_out, .pull_high_disable_out, .irq_out);
    adcc_core_model i_core (.clock_in, .sys_rst_in, .start_in(conv_start_out), .power_in(conv_power_out),
        .delay_in(delay), .value_in(value), .done_out(conv_done_in), .data_out(conv_data_in));

    always #4 clock_in = ~clock_in;

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n == 20) begin
            miscompares++;
            $display("ERROR at %0t: no bus ready", $time);
        end
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rdchk

    function automatic logic [1:0] src_exp(input int s);
        case (s)
            1: return ADCC_MUX_BANDGAP;
            3: return ADCC_MUX_PROT_AMP;
            2, 4: return ADCC_MUX_GROUND;
            default: return ADCC_MUX_EXTERNAL;
        endcase
    endfunction : src_exp

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int a = 0; a <= 24; a += 4) rdchk(8'(a), 32'h0);
        rdchk(8'h1C, 32'h0);
        chk(32'(rerr), 32'h1);
    endtask : t_reset

    task automatic t_pins;
        apb(1'b1, ADCC_ADDR_PIN_EN, 32'hA5);
        @(posedge clock_in);
        chk(32'(analog_pin_enable_bits_out), 32'hA5);
        chk(32'(io_function_disable_out), 32'hA5);
        chk(32'(pull_high_disable_out), 32'hA5);
        rdchk(ADCC_ADDR_PIN_EN, 32'hA5);
    endtask : t_pins

    task automatic t_mux;
        logic ext;
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 9; c++) begin
                ext = (s == 0 || s > 4);
                if (!ext && c < 8) continue;
                apb(1'b1, ADCC_ADDR_PIN_EN, (ext && c < 8) ? 32'h1 << c : 32'h0);
                apb(1'b1, ADCC_ADDR_SRC_CFG, {24'h0, 3'(s), 5'h1B});
                apb(1'b1, ADCC_ADDR_CONV_CTRL, 32'(c));
                @(posedge clock_in);
                chk(32'(mux_source_out), 32'(src_exp(s)));
                chk(32'(mux_pin_sel_out), (ext && c < 8) ? 32'h1 << c : 32'h0);
            end
        end
        chk(32'(vref_sel_out), 32'h3);
        chk(32'(conv_clk_div_out), 32'h3);
    endtask : t_mux

    task automatic t_conv(input logic [11:0] data, input logic [3:0] dly, input logic fmt);
        int n;
        value <= data;
        delay <= dly;
        apb(1'b1, ADCC_ADDR_CONV_CTRL, 32'hA0 | 32'(fmt) << 4);
        apb(1'b1, ADCC_ADDR_CONV_CTRL, 32'h20 | 32'(fmt) << 4);
        apb(1'b0, ADCC_ADDR_CONV_CTRL, 32'h0);
        if (dly > 4) chk(rdat, 32'h60 | 32'(fmt) << 4);
        n = 0;
        while (rdat[6] !== 1'b0 && n < 40) begin
            apb(1'b0, ADCC_ADDR_CONV_CTRL, 32'h0);
            n++;
        end
        chk(rdat, 32'h20 | 32'(fmt) << 4);
        rdchk(ADCC_ADDR_RESULT_HIGH, fmt ? 32'(data[11:8]) : 32'(data[11:4]));
        rdchk(ADCC_ADDR_RESULT_LOW, fmt ? 32'(data[7:0]) : 32'({data[3:0], 4'h0}));
        rdchk(ADCC_ADDR_IRQ_STATUS, 32'h1);
        apb(1'b1, ADCC_ADDR_IRQ_MASK, 32'h1);
        @(posedge clock_in);
        chk(32'(irq_out), 32'h1);
        apb(1'b1, ADCC_ADDR_IRQ_STATUS, 32'h1);
        @(posedge clock_in);
        chk(32'(irq_out), 32'h0);
        apb(1'b1, ADCC_ADDR_IRQ_MASK, 32'h0);
    endtask : t_conv

    task automatic t_disable(input logic [11:0] data);
        value <= ~data;
        apb(1'b1, ADCC_ADDR_CONV_CTRL, 32'h80);
        apb(1'b1, ADCC_ADDR_CONV_CTRL, 32'h00);
        rdchk(ADCC_ADDR_CONV_CTRL, 32'h00);
        chk(32'(conv_power_out), 32'h0);
        rdchk(ADCC_ADDR_RESULT_HIGH, 32'(data[11:4]));
        rdchk(ADCC_ADDR_RESULT_LOW, 32'({data[3:0], 4'h0}));
    endtask : t_disable

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_pins();
        t_mux();
        t_conv(12'hABC, 4'h8, 1'b0);
        t_conv(12'h5E7, 4'h0, 1'b1);
        t_disable(12'h5E7);
        report_and_stop();
    end

    // Whole run needs under a thousand cycles; 10000 leaves margin
    initial begin
        #80000;
        miscompares++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
